// ==== include/msm_consts.vh ====
// Constants for the modem status monitor frame serializer
// Notes on behaviour
// - Frame 0 D7 shows correlation active, D6 shows frame sync found.
// - Frame 0 D4..D0: low power, hop, tx command, idle, fault; D5 zero.
// - Frame 1 D7, D6, D5 pulse on rx ok, ack ok, rx error.
// - Each reception result flag is one 20 us high pulse.
// - Frame 1 D4 high while wakeup packet received; D0 always zero.
// - Frame 1 D3..D1 hold last tx result code; top bit repeater reached.
// - Low code bits: 00 reached, 01 no ack, 10 refused, 11 full.
// - Frame 2 D7 input buffer full, D6 input buffer has data.
// - Frame 2 D5 out full, D4 mode 7, D3 overrun, D2 out has data.
// - Frame 3 D7 host out enable, D6 radio rx, D5 host in enable.
// - Frame 3 D4..D0 carry current channel number, 0 to 23.
// - Id code high byte from higher register, low byte from lower.
// - Id code seeds the scrambler and descrambler.
// - Transmission start blocked while carrier sensed, whatever the code.
// - Frame is 4 address bits then 8 data bits, MSB first, 0 to 4.
// - Data valid at clock rise; load rises at each frame end.
// - Two-bit rate field: 00 off, 100 kHz, 1.14 MHz, 8 MHz; the divider ticks at 1.25 MHz and 10 MHz for the last two.
// - Status clock runs at half the divider tick rate.
`ifndef MSM_CONSTS_VH
`define MSM_CONSTS_VH

`define MSM_CLK_HZ        10000000
`define MSM_PULSE_NS      20000
`define MSM_PULSE_CYC     ((`MSM_PULSE_NS * (`MSM_CLK_HZ / 1000000)) / 1000)

`define MSM_RATE1_HZ      100000
`define MSM_RATE2_HZ      1140000
`define MSM_RATE3_HZ      8000000
`define MSM_DIV1          (`MSM_CLK_HZ / `MSM_RATE1_HZ)
`define MSM_DIV2          (`MSM_CLK_HZ / `MSM_RATE2_HZ)
`define MSM_DIV3          (`MSM_CLK_HZ / `MSM_RATE3_HZ)

`define MSM_ADDR_IDLO     4'h4
`define MSM_ADDR_IDHI     4'h5
`define MSM_ADDR_RATE     4'hB
`define MSM_ADDR_STAT     4'hC
`define MSM_RATE_LSB      4
`define MSM_RATE_RST      8'h00
`define MSM_IDLO_RST      8'h00
`define MSM_IDHI_RST      8'h00

`define MSM_FRAME_BITS    12
`define MSM_LAST_FRAME    4'h4

`endif

// ==== design/msm_pulse_stretch.v ====
// Stretches a one-cycle event into a fixed-length pulse
`timescale 1ns/1ps
`include "msm_consts.vh"
module msm_pulse_stretch
(
  // Clock and reset
  input  wire i_core_clk,
  input  wire i_rst,
  // Event in, pulse out
  input  wire i_event,
  output wire o_pulse
);
  localparam [31:0] LEN_W = `MSM_PULSE_CYC;
  localparam [7:0]  LEN   = LEN_W[7:0];
  reg [7:0] cnt_r;

  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      cnt_r <= 8'h00;
    else if (i_event)
      cnt_r <= LEN;
    else if (cnt_r != 8'h00)
      cnt_r <= cnt_r - 8'h01;
  end

  assign o_pulse = (cnt_r != 8'h00);
endmodule

// ==== design/msm_rate_div.v ====
// Monitor rate divider producing one-cycle tick enables
`timescale 1ns/1ps
`include "msm_consts.vh"
module msm_rate_div
(
  // Clock and reset
  input  wire       i_core_clk,
  input  wire       i_rst,
  // Rate selection and tick
  input  wire [1:0] i_rate_sel,
  output reg        o_tick
);
  localparam [31:0] D1_W = `MSM_DIV1;
  localparam [31:0] D2_W = `MSM_DIV2;
  localparam [31:0] D3_W = `MSM_DIV3;
  localparam [7:0]  D1   = D1_W[7:0];
  localparam [7:0]  D2   = D2_W[7:0];
  localparam [7:0]  D3   = D3_W[7:0];
  reg  [7:0] cnt_r;
  reg  [7:0] limit;

  always @*
  begin
    case (i_rate_sel)
      2'h1:    limit = D1;
      2'h2:    limit = D2;
      2'h3:    limit = (D3 == 8'h00) ? 8'h01 : D3;
      default: limit = 8'h00;
    endcase
  end

  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r  <= 8'h00;
      o_tick <= 1'b0;
    end
    else if (limit == 8'h00)
    begin
      cnt_r  <= 8'h00;
      o_tick <= 1'b0;
    end
    else if (cnt_r + 8'h01 >= limit)
    begin
      cnt_r  <= 8'h00;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r + 8'h01;
      o_tick <= 1'b0;
    end
  end
endmodule

// ==== design/msm_status_monitor.v ====
// Status monitor: frame assembly, serializer, id code registers
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "msm_consts.vh"
module msm_status_monitor
(
  // Clock and reset
  input  wire       i_core_clk,
  input  wire       i_rst,
  // Register port
  input  wire [3:0] i_reg_addr,
  input  wire [7:0] i_reg_wdata,
  input  wire       i_reg_wr,
  input  wire       i_reg_rd,
  output reg  [7:0] o_reg_rdata,
  // Frame 0 status
  input  wire       i_corr_active,
  input  wire       i_sync_found,
  input  wire       i_corr_lost,
  input  wire       i_low_power_mode_active,
  input  wire       i_channel_hop_active,
  input  wire       i_tx_cmd_running,
  input  wire       i_radio_idle,
  input  wire       i_sys_fault,
  // Frame 1 status
  input  wire       i_rx_ok_evt,
  input  wire       i_ack_ok_evt,
  input  wire       i_rx_err_evt,
  input  wire       i_wakeup_rx_active,
  input  wire       i_tx_done,
  input  wire       i_tx_repeater_reached,
  input  wire [1:0] i_tx_outcome,
  // Frame 2 status
  input  wire       i_in_buf_full,
  input  wire       i_in_buf_nonempty,
  input  wire       i_out_buf_full,
  input  wire       i_mode7_active,
  input  wire       i_out_buf_overrun,
  input  wire       i_out_buf_nonempty,
  // Frame 3 and 4 status
  input  wire       i_host_out_en,
  input  wire       i_radio_rx_en,
  input  wire       i_host_in_en,
  input  wire [4:0] i_current_channel,
  input  wire [4:0] i_top_state,
  // Transmit gating
  input  wire       i_carrier_sense,
  input  wire       i_tx_request,
  output reg        o_tx_start,
  output reg [15:0] o_scramble_seed,
  // Status serial pins
  output reg        o_status_data,
  output reg        o_status_clk,
  output reg        o_status_load
);
  // Frame length cut to the bit counter width
  localparam [31:0] FRAME_BITS_W = `MSM_FRAME_BITS;
  localparam [3:0]  FRAME_BITS   = FRAME_BITS_W[3:0];
  localparam [3:0] LAST_FRAME = `MSM_LAST_FRAME;
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SHIFT = 3'b010;
  localparam [2:0] ST_LOAD = 3'b100;

  reg  [7:0]  id_code_low_byte_r;
  reg  [7:0]  id_code_high_byte_r;
  reg  [7:0]  monitor_rate_reg_r;
  reg         sync_found_r;
  reg  [2:0]  tx_result_code_r;
  reg         carrier_s1_r;
  reg         carrier_s2_r;
  reg  [2:0]  state_r;
  reg  [3:0]  frame_addr_r;
  reg  [3:0]  bit_cnt_r;
  reg  [11:0] shift_r;
  reg         phase_r;
  wire        tick;
  wire        rx_ok_pulse;
  wire        ack_ok_pulse;
  wire        rx_err_pulse;
  wire [1:0]  rate_sel;

  assign rate_sel = monitor_rate_reg_r[`MSM_RATE_LSB+1:`MSM_RATE_LSB];

  // Assembles the status byte for one frame address
  function [7:0] frame_byte;
    input [3:0] addr;
    begin
      case (addr)
        4'h0: frame_byte = {i_corr_active, sync_found_r, 1'b0,
                            i_low_power_mode_active,
                            i_channel_hop_active, i_tx_cmd_running,
                            i_radio_idle, i_sys_fault};
        4'h1: frame_byte = {rx_ok_pulse, ack_ok_pulse, rx_err_pulse,
                            i_wakeup_rx_active, tx_result_code_r,
                            1'b0};
        4'h2: frame_byte = {i_in_buf_full, i_in_buf_nonempty,
                            i_out_buf_full, i_mode7_active,
                            i_out_buf_overrun, i_out_buf_nonempty,
                            2'b00};
        4'h3: frame_byte = {i_host_out_en, i_radio_rx_en, i_host_in_en,
                            i_current_channel};
        4'h4: frame_byte = {3'b000, i_top_state};
        default: frame_byte = 8'h00;
      endcase
    end
  endfunction

  msm_pulse_stretch u_rx_ok
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_event    (i_rx_ok_evt),
    .o_pulse    (rx_ok_pulse)
  );

  msm_pulse_stretch u_ack_ok
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_event    (i_ack_ok_evt),
    .o_pulse    (ack_ok_pulse)
  );

  msm_pulse_stretch u_rx_err
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_event    (i_rx_err_evt),
    .o_pulse    (rx_err_pulse)
  );

  msm_rate_div u_div
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_rate_sel (rate_sel),
    .o_tick     (tick)
  );

  // Write strobe aimed at one register address
  function reg_hit;
    input [3:0] addr;
    begin
      reg_hit = i_reg_wr && (i_reg_addr == addr);
    end
  endfunction

  // Read value of one register address; unmapped reads give zero
  function [7:0] reg_value;
    input [3:0] addr;
    begin
      case (addr)
        `MSM_ADDR_IDLO: reg_value = id_code_low_byte_r;
        `MSM_ADDR_IDHI: reg_value = id_code_high_byte_r;
        `MSM_ADDR_RATE: reg_value = monitor_rate_reg_r;
        `MSM_ADDR_STAT: reg_value = {4'h0, frame_addr_r};
        default:        reg_value = 8'h00;
      endcase
    end
  endfunction

  // Id code byte registers
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      id_code_low_byte_r  <= `MSM_IDLO_RST;
      id_code_high_byte_r <= `MSM_IDHI_RST;
    end
    else
    begin
      if (reg_hit(`MSM_ADDR_IDLO))
        id_code_low_byte_r  <= i_reg_wdata;
      if (reg_hit(`MSM_ADDR_IDHI))
        id_code_high_byte_r <= i_reg_wdata;
    end
  end

  // Monitor rate register, its field selects the divider
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      monitor_rate_reg_r <= `MSM_RATE_RST;
    else if (reg_hit(`MSM_ADDR_RATE))
      monitor_rate_reg_r <= i_reg_wdata;
  end

  // Register reads, one cycle later
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
      o_reg_rdata <= reg_value(i_reg_addr);
    else
      o_reg_rdata <= 8'h00;
  end

  // Scrambler seed follows the id code registers
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      o_scramble_seed <= 16'h0000;
    else
      o_scramble_seed <= {id_code_high_byte_r,
                          id_code_low_byte_r};
  end

  // Frame sync latch, a set wins over a clear in the same cycle
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      sync_found_r <= 1'b0;
    else if (i_sync_found)
      sync_found_r <= 1'b1;
    else if (i_corr_lost)
      sync_found_r <= 1'b0;
  end

  // Result code of the last transmit command
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      tx_result_code_r <= 3'h0;
    else if (i_tx_done)
      tx_result_code_r <= {i_tx_repeater_reached,
                           i_tx_outcome};
  end

  // Carrier pin synchroniser; no start while carrier is sensed
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      carrier_s1_r <= 1'b0;
      carrier_s2_r <= 1'b0;
      o_tx_start   <= 1'b0;
    end
    else
    begin
      carrier_s1_r <= i_carrier_sense;
      carrier_s2_r <= carrier_s1_r;
      o_tx_start   <= i_tx_request & ~carrier_s2_r;
    end
  end

  // Serializer: one bit per two ticks, clock rises mid-bit
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r       <= ST_IDLE;
      frame_addr_r  <= 4'h0;
      bit_cnt_r     <= 4'h0;
      shift_r       <= 12'h000;
      phase_r       <= 1'b0;
      o_status_data <= 1'b0;
      o_status_clk  <= 1'b0;
      o_status_load <= 1'b0;
    end
    else if (rate_sel == 2'b00)
    begin
      state_r       <= ST_IDLE;
      frame_addr_r  <= 4'h0;
      phase_r       <= 1'b0;
      o_status_data <= 1'b0;
      o_status_clk  <= 1'b0;
      o_status_load <= 1'b0;
    end
    else if (tick)
    begin
      case (state_r)
        ST_IDLE:
        begin
          shift_r   <= {frame_addr_r, frame_byte(frame_addr_r)};
          bit_cnt_r <= 4'h0;
          phase_r   <= 1'b0;
          o_status_load <= 1'b0;
          state_r   <= ST_SHIFT;
        end
        ST_SHIFT:
        begin
          phase_r <= ~phase_r;
          if (!phase_r)
          begin
            o_status_data <= shift_r[11];
            o_status_clk  <= 1'b0;
          end
          else
          begin
            o_status_clk <= 1'b1;
            shift_r      <= {shift_r[10:0], 1'b0};
            if (bit_cnt_r == FRAME_BITS - 4'h1)
              state_r <= ST_LOAD;
            else
              bit_cnt_r <= bit_cnt_r + 4'h1;
          end
        end
        ST_LOAD:
        begin
          o_status_clk  <= 1'b0;
          o_status_load <= 1'b1;
          frame_addr_r  <= (frame_addr_r == LAST_FRAME) ? 4'h0
                           : frame_addr_r + 4'h1;
          state_r       <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// ==== testbench/msm_props.sv ====
// Port checker for the status monitor
`timescale 1ns/1ps
`include "msm_consts.vh"
module msm_props
(
  // Clock, reset and register port
  input logic        i_core_clk,
  input logic        i_rst,
  input logic [3:0]  i_reg_addr,
  input logic [7:0]  i_reg_wdata,
  input logic        i_reg_wr,
  input logic        i_reg_rd,
  input logic [7:0]  o_reg_rdata,
  // Transmit gating and serial pins
  input logic        i_carrier_sense,
  input logic        o_tx_start,
  input logic [15:0] o_scramble_seed,
  input logic        o_status_data,
  input logic        o_status_clk,
  input logic        o_status_load
);
  logic [1:0] rate_r;
  logic       clk_q;
  logic [4:0] rise_cnt;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // Copy of the rate field and a count of status clock rises
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rate_r   <= 2'h0;
      clk_q    <= 1'b0;
      rise_cnt <= 5'h00;
    end
    else
    begin
      clk_q <= o_status_clk;
      if (i_reg_wr && i_reg_addr == `MSM_ADDR_RATE)
        rate_r <= i_reg_wdata[5:4];
      if (o_status_load || rate_r == 2'h0)
        rise_cnt <= 5'h00;
      else if (o_status_clk && !clk_q)
        rise_cnt <= rise_cnt + 5'h01;
    end
  end
  sequence s_mid_rise;
    rate_r == 2'h2 ##0 $rose(o_status_clk);
  endsequence
  sequence s_high8;
    o_status_clk [*8] ##1 !o_status_clk;
  endsequence
  a_rd_idle_zero: assert property (
    !$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_rd_low_seed: assert property (
    $past(i_reg_rd) && $past(i_reg_addr) == `MSM_ADDR_IDLO
    |-> o_reg_rdata == o_scramble_seed[7:0])
    else $error("low id byte differs from seed");
  a_seed_high: assert property (
    i_reg_wr && i_reg_addr == `MSM_ADDR_IDHI
    |-> ##2 o_scramble_seed[15:8] == $past(i_reg_wdata, 2))
    else $error("seed high byte not from high register");
  a_tx_blocked: assert property (
    i_carrier_sense [*4] |-> !o_tx_start)
    else $error("transmit started under carrier");
  a_load_clk_low: assert property (
    o_status_load |-> !o_status_clk)
    else $error("status clock high during load");
  a_data_steady: assert property (
    o_status_clk |-> $stable(o_status_data))
    else $error("status data moved while clock high");
  a_frame_bits: assert property (
    $rose(o_status_load) |-> rise_cnt == 5'h0C)
    else $error("frame not twelve clocks long");
  a_half_rate: assert property (s_mid_rise |-> s_high8)
    else $error("status clock high phase not one tick");
endmodule

// ==== testbench/msm_status_rx.sv ====
// Status frame receiver at the auxiliary pins
`timescale 1ns/1ps
module msm_status_rx
(
  // Clock
  input  logic       i_core_clk,
  // Status serial pins
  input  logic       i_data,
  input  logic       i_sclk,
  input  logic       i_load,
  // Captured frame
  output logic [3:0] o_addr,
  output logic [7:0] o_byte,
  output logic       o_got
);
  logic [11:0] sh_r;
  logic        sclk_q;
  logic        load_q;
  always @(posedge i_core_clk)
  begin
    sclk_q <= i_sclk;
    load_q <= i_load;
    o_got  <= i_load && !load_q;
    if (i_sclk && !sclk_q)
      sh_r <= {sh_r[10:0], i_data};
    if (i_load && !load_q)
      {o_addr, o_byte} <= sh_r;
  end
endmodule

// ==== testbench/tb.sv ====
// Testbench for the status monitor
`timescale 1ns/1ps
`include "msm_consts.vh"
module tb;
  logic        clk, rst, wr_s, rd_s, sync, lost, wake, done, rep;
  logic        cs, req, tx_start, sd, sc, sl, got, sy;
  logic [3:0]  addr, ra, a;
  logic [7:0]  wd, rdata, s0, s2, s3, rb, b;
  logic [4:0]  top;
  logic [2:0]  ev, pl;
  logic [1:0]  code;
  logic [15:0] seed;
  int          fail_count, compares, p, k, dv;
  msm_status_monitor i_dut
  (
    .i_core_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wd),
    .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata),
    .i_corr_active(s0[7]), .i_sync_found(sync), .i_corr_lost(lost),
    .i_low_power_mode_active(s0[4]), .i_channel_hop_active(s0[3]),
    .i_tx_cmd_running(s0[2]), .i_radio_idle(s0[1]), .i_sys_fault(s0[0]),
    .i_rx_ok_evt(ev[2]), .i_ack_ok_evt(ev[1]), .i_rx_err_evt(ev[0]),
    .i_wakeup_rx_active(wake), .i_tx_done(done),
    .i_tx_repeater_reached(rep), .i_tx_outcome(code),
    .i_in_buf_full(s2[7]), .i_in_buf_nonempty(s2[6]),
    .i_out_buf_full(s2[5]), .i_mode7_active(s2[4]),
    .i_out_buf_overrun(s2[3]), .i_out_buf_nonempty(s2[2]),
    .i_host_out_en(s3[7]), .i_radio_rx_en(s3[6]), .i_host_in_en(s3[5]),
    .i_current_channel(s3[4:0]), .i_top_state(top),
    .i_carrier_sense(cs), .i_tx_request(req), .o_tx_start(tx_start),
    .o_scramble_seed(seed), .o_status_data(sd), .o_status_clk(sc),
    .o_status_load(sl)
  );
  msm_status_rx i_rx
  (
    .i_core_clk(clk), .i_data(sd), .i_sclk(sc), .i_load(sl),
    .o_addr(ra), .o_byte(rb), .o_got(got)
  );
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [7:0] exp_f(input int f);
    case (f)
      0: exp_f = {s0[7], sy, 1'b0, s0[4:0]};
      1: exp_f = {pl, wake, rep, code, 1'b0};
      2: exp_f = {s2[7:2], 2'b00};
      3: exp_f = s3;
      default: exp_f = {3'b000, top};
    endcase
  endfunction
  task automatic close_out;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want)
    begin
      fail_count++;
      $display("FAIL %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    addr <= ad;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] ad, input logic [7:0] want);
    addr <= ad;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, want});
    @(posedge clk);
  endtask
  // Next received frame, bounded wait
  task automatic get;
    int n;
    for (n = 0; n < 14000 && got !== 1'b1; n++)
      @(posedge clk);
    if (n == 14000)
    begin
      fail_count++;
      $display("FAIL %0t: no frame", $time);
      close_out();
    end
    a = ra;
    b = rb;
    @(posedge clk);
  endtask
  task automatic seek(input logic [3:0] x);
    int n;
    get();
    for (n = 0; n < 6 && a !== x; n++)
      get();
    chk({12'h000, a}, {12'h000, x});
  endtask
  initial
  begin
    {rst, wr_s, rd_s, sync, lost, wake, done, rep, cs, req} = 10'h200;
    {addr, wd, s0, s2, s3, top, ev, code, pl, sy} = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`MSM_ADDR_IDLO, 8'h00);
    rd(`MSM_ADDR_RATE, 8'h00);
    wr(4'h7, 8'hA5);
    rd(4'h7, 8'h00);
    wr(`MSM_ADDR_IDHI, 8'h67);
    wr(`MSM_ADDR_IDLO, 8'hB2);
    rd(`MSM_ADDR_IDHI, 8'h67);
    chk(seed, 16'h67B2);
    wr(`MSM_ADDR_IDHI, 8'hEF);
    wr(`MSM_ADDR_IDLO, 8'hFF);
    @(negedge clk);
    chk(seed, 16'hEFFF);
    @(posedge clk);
    cs <= 1'b1;
    req <= 1'b1;
    repeat (6) @(posedge clk);
    chk({15'h0, tx_start}, 16'h0000);
    cs <= 1'b0;
    repeat (4) @(posedge clk);
    chk({15'h0, tx_start}, 16'h0001);
    req <= 1'b0;
    wr(`MSM_ADDR_RATE, 8'h30);
    rd(`MSM_ADDR_RATE, 8'h30);
    for (p = 0; p < 4; p++)
    begin
      s0 <= p[0] ? 8'h6A : 8'h95;
      s2 <= p[0] ? 8'h57 : 8'hA8;
      s3 <= {p[0] ? 3'h5 : 3'h2, p[1] ? 5'h17 : 5'h00};
      top <= p[0] ? 5'h15 : 5'h0A;
      {wake, rep, code, done} <= {p[0], p[1], p[1:0], 1'b1};
      {sync, lost, sy} <= {p[0], !p[0], p[0]};
      @(posedge clk);
      {done, sync, lost} <= 3'h0;
      seek(4'h4);
      for (k = 0; k < 5; k++)
      begin
        get();
        chk({a, b}, {k[3:0], exp_f(k)});
        chk({a, b}, {k[3:0], exp_f(k)});
        chk({a, b}, {k[3:0], exp_f(k)});
      end
    end
    seek(4'h0);
    ev <= 3'h7;
    @(posedge clk);
    ev <= 3'h0;
    seek(4'h1);
    seek(4'h1);
    pl = 3'h7;
    chk({8'h00, b}, {8'h00, exp_f(1)});
    seek(4'h1);
    pl = 3'h0;
    chk({8'h00, b}, {8'h00, exp_f(1)});
    for (p = 3; p > 0; p--)
    begin
      wr(`MSM_ADDR_RATE, 8'h00);
      repeat (4) @(posedge clk);
      chk({13'h0, sc, sl, sd}, 16'h0000);
      rd(`MSM_ADDR_STAT, 8'h00);
      wr(`MSM_ADDR_RATE, {2'b00, p[1:0], 4'h0});
      get();
      chk({12'h000, a}, 16'h0000);
      dv = (2 * `MSM_FRAME_BITS + 2) * (p == 1 ? `MSM_DIV1
           : p == 2 ? `MSM_DIV2 : `MSM_DIV3);
      for (k = 0; k < 3000 && got !== 1'b1; k++)
        @(posedge clk);
      chk(k[15:0] + 16'h0001, dv[15:0]);
    end
    close_out();
  end
endmodule
bind msm_status_monitor msm_props i_props
(
  .i_core_clk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
  .o_reg_rdata, .i_carrier_sense, .o_tx_start, .o_scramble_seed,
  .o_status_data, .o_status_clk, .o_status_load
);
